//--- design/irpd_decoder.sv
// Infrared pulse-distance frame decoder with LED channel select and idle stop.
// Assumes one 40 MHz clock; receive pin and low-speed clock arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none
`include "irpd_params.svh"

module irpd_decoder #(
	parameter int IDLE_TICKS = `IRPD_IDLE_MS * 32'h3E8 / `IRPD_TICK_US, // Ticks before stop
	parameter int TICK_CYCLES = `IRPD_TICK_US * `IRPD_CLK_MHZ // Clock cycles per tick
) (
	input wire logic mclk, // System clock, 40 MHz
	input wire logic reset, // Asynchronous reset, active high
	input wire logic ir_rx, // Receiver pin, active low marks
	input wire logic subsystem_low_clock, // Low-speed filter sampling clock
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	output logic irq, // Level interrupt
	output logic [1:0] irq_prio, // Interrupt priority level
	output logic [7:0] led, // LED1..LED8, active high
	output logic autonomous_low_power_state // Stopped state flag
);
	// Tick divider length derived from rate and tick period
	localparam int TICK_CYC = TICK_CYCLES;
	localparam int IW = $clog2(IDLE_TICKS + 1);
	localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_TICKS - 1);
	localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);

	// Refuse counts the logic cannot serve
	if (IDLE_TICKS < 2) begin : g_chk_idle
		$error("IDLE_TICKS must be at least 2");
	end
	// Divider is 12 bits; tick spacing check wants at least nine cycles
	if (TICK_CYC > 4096 || TICK_CYC < 9) begin : g_chk_tick
		$error("Tick divider must be 9 to 4096 cycles");
	end

	// Whole state of the block
	typedef struct packed {
		logic rx_m; // Pin sync, first stage
		logic rx_s; // Pin sync, second stage
		logic lc_m; // Low clock sync, first stage
		logic lc_s; // Low clock sync, second stage
		logic lc_p; // Low clock previous, edge detect
		logic [2:0] smp; // Last three filter samples
		logic flt; // Filtered, inverted level
		logic flt_p; // Previous filtered level
		logic [11:0] div; // Tick divider
		logic [7:0] width; // Ticks since last mark edge
		irpd_pkg::irpd_state_t st; // Frame state
		logic [5:0] nbit; // Bits collected
		logic [31:0] sh; // Shift register, LSB first
		logic [31:0] data; // Last good frame
		logic [3:0] stat; // Sticky events
		logic [3:0] ien; // Interrupt enables
		logic [1:0] ctrl; // Enable and inversion
		logic [IW-1:0] idle; // Inactivity ticks
		logic stopped; // Low-power stopped state
		logic [7:0] led; // LED drive
		logic [31:0] rdata; // Read data
	} irpd_regs_t;

	irpd_regs_t q, d;

	// Inclusive window test, used for every pattern class
	function automatic logic in_win(input logic [7:0] w, input logic [7:0] lo, input logic [7:0] hi);
		in_win = (w >= lo) && (w <= hi);
	endfunction : in_win

	// Channel byte to one-hot LED, zero for any other code
	function automatic logic [7:0] led_decode(input logic [7:0] b);
		logic [7:0] off;
		off = b - `IRPD_LED_BASE;
		led_decode = 8'h00;
		if (b >= `IRPD_LED_BASE && off < 8'h08) begin
			led_decode = 8'(8'h01 << off[2:0]);
		end
	endfunction : led_decode

	// Combinational events seen by assertions too
	logic tick, mark_edge, ev_cmp, ev_done, ev_spc, ev_idle, ev_rx;
	logic [31:0] sh_next;

	// Next-state logic for the whole block
	always_comb begin
		logic bit_ok;
		logic bit_val;
		logic [3:0] ev;
		d = q;
		bit_ok = 1'b0;
		bit_val = 1'b0;
		ev = 4'h0;
		ev_cmp = 1'b0;
		ev_done = 1'b0;
		ev_spc = 1'b0;
		ev_idle = 1'b0;
		sh_next = q.sh;

		// Two-stage synchronisers; first stages feed nothing else
		d.rx_m = ir_rx;
		d.rx_s = q.rx_m;
		d.lc_m = subsystem_low_clock;
		d.lc_s = q.lc_m;
		d.lc_p = q.lc_s;

		// Sample on each low clock rising edge, accept after three equal
		if (q.lc_s && !q.lc_p) begin
			d.smp = {q.smp[1:0], q.rx_s ^ q.ctrl[`IRPD_CTRL_INV]};
			if (d.smp == 3'b111) begin
				d.flt = 1'b1;
			end else if (d.smp == 3'b000) begin
				d.flt = 1'b0;
			end
		end
		d.flt_p = q.flt;

		// Tick generator: one pulse per tick period
		tick = (q.div == TICK_LAST);
		d.div = tick ? 12'h000 : q.div + 12'h001;

		// Mark start after inversion is the measuring edge
		mark_edge = q.flt && !q.flt_p;

		// Width counter saturates so long gaps stay long
		if (tick && q.width != 8'hFF) begin
			d.width = q.width + 8'h01;
		end

		// Frame receiver
		if (!q.ctrl[`IRPD_CTRL_EN]) begin
			d.st = irpd_pkg::IRPD_IDLE;
			d.width = 8'h00;
		end else if (mark_edge) begin
			d.width = 8'h00;
			case (q.st)
				irpd_pkg::IRPD_IDLE: begin
					// First mark opens the leading pattern
					d.st = irpd_pkg::IRPD_LEAD;
				end
				irpd_pkg::IRPD_LEAD: begin
					if (in_win(q.width, `IRPD_HDR_MIN, `IRPD_HDR_MAX)) begin
						d.st = irpd_pkg::IRPD_DATA;
						d.nbit = 6'h00;
					end else if (in_win(q.width, `IRPD_SPC_MIN, `IRPD_SPC_MAX)) begin
						ev_spc = 1'b1;
					end
					// Anything else restarts measurement from this mark
				end
				irpd_pkg::IRPD_DATA: begin
					if (in_win(q.width, `IRPD_D0_MIN, `IRPD_D0_MAX)) begin
						bit_ok = 1'b1;
						bit_val = 1'b0;
					end else if (in_win(q.width, `IRPD_D1_MIN, `IRPD_D1_MAX)) begin
						bit_ok = 1'b1;
						bit_val = 1'b1;
					end
					if (bit_ok) begin
						sh_next = {bit_val, q.sh[31:1]};
						d.sh = sh_next;
						d.nbit = q.nbit + 6'h01;
						// Address check once 15 bits are in
						if (d.nbit == `IRPD_CMP_BITS &&
							sh_next[31:17] == 15'(`IRPD_CMP_VAL)) begin
							ev_cmp = 1'b1;
						end
						if (d.nbit == `IRPD_FRAME_BITS) begin
							d.data = sh_next;
							ev_done = 1'b1;
							d.st = irpd_pkg::IRPD_LEAD;
						end
					end else begin
						// Error: frame dropped, capture untouched
						d.st = irpd_pkg::IRPD_LEAD;
					end
				end
				default: begin
					d.st = irpd_pkg::IRPD_IDLE;
				end
			endcase
		end else if (q.st != irpd_pkg::IRPD_IDLE && q.width >= `IRPD_END_W) begin
			// Pattern end: silence closes any frame, partial ones lost
			d.st = irpd_pkg::IRPD_IDLE;
		end

		// Receiver activity and inactivity timer
		ev_rx = ev_cmp | ev_done | ev_spc;
		if (q.stopped) begin
			d.idle = '0;
			if (ev_rx) begin
				d.stopped = 1'b0;
			end
		end else if (ev_done || ev_spc) begin
			d.idle = '0;
		end else if (tick) begin
			if (q.idle == IDLE_LAST) begin
				ev_idle = 1'b1;
				d.stopped = 1'b1;
				d.idle = '0;
			end else begin
				d.idle = q.idle + IW'(1);
			end
		end

		// LED control
		if (ev_done) begin
			d.led = led_decode(sh_next[23:16]);
		end
		if (ev_idle || d.stopped) begin
			d.led = 8'h00;
		end

		// Sticky status: a new event beats a clear in the same cycle
		ev[`IRPD_EV_CMP] = ev_cmp;
		ev[`IRPD_EV_DONE] = ev_done;
		ev[`IRPD_EV_SPC] = ev_spc;
		ev[`IRPD_EV_IDLE] = ev_idle;
		if (reg_wr && reg_addr == `IRPD_REG_CLR) begin
			d.stat = (q.stat & ~reg_wdata[3:0]) | ev;
		end else begin
			d.stat = q.stat | ev;
		end

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				`IRPD_REG_CTRL: begin
					d.ctrl = reg_wdata[1:0];
				end
				`IRPD_REG_IEN: begin
					d.ien = reg_wdata[3:0];
				end
				default: begin
					// Read-only and unmapped writes ignored
				end
			endcase
		end

		// Register reads, answered next cycle; zero elsewhere
		d.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`IRPD_REG_CTRL: d.rdata = {30'h0, q.ctrl};
				`IRPD_REG_STAT: d.rdata = {28'h0, q.stat};
				`IRPD_REG_IEN: d.rdata = {28'h0, q.ien};
				`IRPD_REG_DATA: d.rdata = q.data;
				`IRPD_REG_STATE: d.rdata = {16'h0, q.led, 6'h0, q.st};
				default: d.rdata = 32'h0000_0000;
			endcase
			if (reg_addr == `IRPD_REG_STATE) begin
				d.rdata[2] = q.stopped;
			end
		end
	end

	// State register; reset gives constants only
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			q <= '0;
			q.ctrl <= `IRPD_CTRL_RST;
			q.st <= irpd_pkg::IRPD_IDLE;
		end else begin
			q <= d;
		end
	end

	// Outputs
	assign reg_rdata = q.rdata;
	assign irq = |(q.stat & q.ien);
	assign irq_prio = `IRPD_IRQ_PRIO;
	assign led = q.led;
	assign autonomous_low_power_state = q.stopped;

	// Helper: mark edge in lead state with the receiver enabled; the assertion checks the header window
	logic hdr_seen;
	assign hdr_seen = mark_edge && q.ctrl[`IRPD_CTRL_EN] && q.st == irpd_pkg::IRPD_LEAD;

	a_tick_period: assert property (@(posedge mclk) disable iff (reset)
		tick |=> !tick [*8]) else $error("Tick repeated too soon");

	a_hdr_window: assert property (@(posedge mclk) disable iff (reset)
		hdr_seen && q.width >= `IRPD_HDR_MIN && q.width <= `IRPD_HDR_MAX
		|=> q.st == irpd_pkg::IRPD_DATA && q.nbit == 6'h00) else $error("Header not accepted");

	a_spc_window: assert property (@(posedge mclk) disable iff (reset)
		ev_spc |-> q.width >= `IRPD_SPC_MIN && q.width <= `IRPD_SPC_MAX && q.st == irpd_pkg::IRPD_LEAD)
		else $error("Repeat flagged outside window");

	a_cmp_value: assert property (@(posedge mclk) disable iff (reset)
		ev_cmp |=> q.nbit == `IRPD_CMP_BITS && q.sh[31:17] == 15'(`IRPD_CMP_VAL) && q.stat[`IRPD_EV_CMP])
		else $error("Compare match wrong");

	a_done_capture: assert property (@(posedge mclk) disable iff (reset)
		ev_done |=> q.data == $past(sh_next) && q.stat[`IRPD_EV_DONE] && q.st == irpd_pkg::IRPD_LEAD)
		else $error("Frame not captured");

	a_no_err_cap: assert property (@(posedge mclk) disable iff (reset)
		!ev_done |=> $stable(q.data)) else $error("Capture without complete frame");

	a_led_onehot: assert property (@(posedge mclk) disable iff (reset)
		$countones(led) <= 1) else $error("More than one LED on");

	a_led_stopped: assert property (@(posedge mclk) disable iff (reset)
		autonomous_low_power_state |-> led == 8'h00) else $error("LED lit while stopped");

	a_idle_stop: assert property (@(posedge mclk) disable iff (reset)
		ev_idle |=> autonomous_low_power_state && q.stat[`IRPD_EV_IDLE] && q.idle == '0)
		else $error("Idle expiry did not stop");

	a_wake: assert property (@(posedge mclk) disable iff (reset)
		q.stopped && ev_rx |=> !autonomous_low_power_state) else $error("No wake on event");

	a_activity: assert property (@(posedge mclk) disable iff (reset)
		!q.stopped && (ev_done || ev_spc) |=> q.idle == '0) else $error("Idle count not restarted");

	a_irq_level: assert property (@(posedge mclk) disable iff (reset)
		(irq == |(q.stat & q.ien)) and ($rose(q.stat[`IRPD_EV_SPC]) |-> $past(ev_spc)))
		else $error("Interrupt level or status wrong");

	a_bit_zero: assert property (@(posedge mclk) disable iff (reset)
		mark_edge && q.ctrl[`IRPD_CTRL_EN] && q.st == irpd_pkg::IRPD_DATA &&
		in_win(q.width, `IRPD_D0_MIN, `IRPD_D0_MAX) |=> !q.sh[31]) else $error("Zero bit not shifted in");

	a_bit_one: assert property (@(posedge mclk) disable iff (reset)
		mark_edge && q.ctrl[`IRPD_CTRL_EN] && q.st == irpd_pkg::IRPD_DATA &&
		in_win(q.width, `IRPD_D1_MIN, `IRPD_D1_MAX) |=> q.sh[31]) else $error("One bit not shifted in");

	a_led_first: assert property (@(posedge mclk) disable iff (reset)
		ev_done && sh_next[23:16] == `IRPD_LED_BASE |=> led == 8'h01) else $error("First channel LED wrong");

	a_led_foreign: assert property (@(posedge mclk) disable iff (reset)
		ev_done && sh_next[23:19] != 5'h02 |=> led == 8'h00) else $error("Foreign code lit an LED");

	a_end_idle: assert property (@(posedge mclk) disable iff (reset)
		q.ctrl[`IRPD_CTRL_EN] && !mark_edge && q.st != irpd_pkg::IRPD_IDLE && q.width >= `IRPD_END_W
		|=> q.st == irpd_pkg::IRPD_IDLE) else $error("Silence did not end frame");

	a_rx_disabled: assert property (@(posedge mclk) disable iff (reset)
		!q.ctrl[`IRPD_CTRL_EN] |=> q.st == irpd_pkg::IRPD_IDLE) else $error("Receiver ran while off");

	a_repeat_nocap: assert property (@(posedge mclk) disable iff (reset)
		ev_spc |=> $stable(q.data) && q.stat[`IRPD_EV_SPC]) else $error("Repeat touched capture");

	a_done_sticky: assert property (@(posedge mclk) disable iff (reset)
		q.stat[`IRPD_EV_DONE] && !(reg_wr && reg_addr == `IRPD_REG_CLR && reg_wdata[`IRPD_EV_DONE])
		|=> q.stat[`IRPD_EV_DONE]) else $error("Complete flag lost without clear");

	a_filter_three: assert property (@(posedge mclk) disable iff (reset)
		$rose(q.flt) |-> $past(q.smp) == 3'b111 || $past(d.smp) == 3'b111) else $error("Filter too quick");

endmodule : irpd_decoder
`default_nettype wire

//--- design/irpd_params.svh
// Constants of the infrared pulse-distance decoder: widths, limits, offsets.
// Assumes inclusion by bare name from package and design files.
`ifndef IRPD_PARAMS_SVH
`define IRPD_PARAMS_SVH

// Timing figures in their own units, clock rate in MHz
`define IRPD_CLK_MHZ 32'h28
`define IRPD_TICK_US 32'h64
`define IRPD_IDLE_MS 32'h2710
// Pulse-distance windows in ticks, inclusive bounds
`define IRPD_HDR_MIN 8'h7A
`define IRPD_HDR_MAX 8'h9E
`define IRPD_D0_MIN 8'h09
`define IRPD_D0_MAX 8'h0D
`define IRPD_D1_MIN 8'h12
`define IRPD_D1_MAX 8'h1A
`define IRPD_SPC_MIN 8'h5C
`define IRPD_SPC_MAX 8'h79
`define IRPD_END_W 8'hC4
// Frame layout and address compare
`define IRPD_FRAME_BITS 6'h20
`define IRPD_CMP_BITS 6'h0F
`define IRPD_CMP_VAL 16'hE718
`define IRPD_LED_BASE 8'h10
`define IRPD_IRQ_PRIO 2'h3
// Register byte offsets
`define IRPD_REG_CTRL 8'h00
`define IRPD_REG_STAT 8'h04
`define IRPD_REG_CLR 8'h08
`define IRPD_REG_IEN 8'h0C
`define IRPD_REG_DATA 8'h10
`define IRPD_REG_STATE 8'h14
// Status bit positions
`define IRPD_EV_CMP 0
`define IRPD_EV_DONE 1
`define IRPD_EV_SPC 2
`define IRPD_EV_IDLE 3
// Control bits and reset value: receiver on, inversion on
`define IRPD_CTRL_EN 0
`define IRPD_CTRL_INV 1
`define IRPD_CTRL_RST 2'h3

`endif

//--- design/irpd_pkg.sv
// Types shared by the infrared pulse-distance decoder.
// Assumes the constants header sits beside it.
`include "irpd_params.svh"

package irpd_pkg;
	// Frame receiver states
	typedef enum logic [1:0] {
		IRPD_IDLE = 2'b00, // No frame, waiting for a mark
		IRPD_LEAD = 2'b01, // Mark seen, measuring leading pattern
		IRPD_DATA = 2'b10 // Header accepted, collecting bits
	} irpd_state_t;
endpackage : irpd_pkg

//--- verification/irpd_remote_model.sv
// Handheld remote plus demodulating receiver, behavioural.
// Assumes 1 ns units; the pin idles high as a pulled-up receiver output.
`timescale 1ns/10ps
`default_nettype none

module irpd_remote_model (
	output logic ir_rx // Receiver output, low in a mark
);
	localparam int TICK = 32'hFA; // One shortened tick in ns
	localparam int SPIKE = 32'h64; // Noise spike in ns, under one filter sample
	localparam int HDR = 32'h87; // Header period, ticks
	localparam int REP = 32'h6E; // Repeat period, ticks
	localparam int ONE = 32'h14; // Data one period
	localparam int ZERO = 32'h0B; // Data zero period
	localparam int BAD = 32'h28; // Width outside every window
	localparam int LMARK = 32'h5A; // Leading mark length
	localparam int BMARK = 32'h05; // Bit mark length

	// Idle level of the pulled-up line
	initial ir_rx = 1'b1;

	// Mark then space; period measured start to start
	task automatic pulse(input int w, input int m, input bit spike);
		ir_rx = 1'b0;
		#(m * TICK);
		ir_rx = 1'b1;
		// A spike mid-space must never reach the classifier
		if (spike) begin
			#((w - m) * TICK / 2);
			ir_rx = 1'b0;
			#SPIKE;
			ir_rx = 1'b1;
			#((w - m) * TICK / 2 - SPIKE);
		end else begin
			#((w - m) * TICK);
		end
	endtask : pulse

	// Closing mark that ends the last period
	task automatic end_mark();
		ir_rx = 1'b0;
		#(BMARK * TICK);
		ir_rx = 1'b1;
	endtask : end_mark

	// Header plus bits LSB first; cut below 32 breaks the frame there
	task automatic send_frame(input int gap, input logic [31:0] word, input int cut);
		#(gap * TICK);
		pulse(HDR, LMARK, 1'b0);
		for (int k = 0; k < cut; k++) begin
			pulse(word[k] ? ONE : ZERO, BMARK, 1'b1);
		end
		if (cut < 32) begin
			pulse(BAD, BMARK, 1'b1);
		end
		end_mark();
	endtask : send_frame

	// Lone repeat code after a gap
	task automatic send_repeat(input int gap);
		#(gap * TICK);
		pulse(REP, LMARK, 1'b0);
		end_mark();
	endtask : send_repeat
endmodule : irpd_remote_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the infrared pulse-distance decoder.
// Assumes the remote model drives the pin; tick shortened to 10 cycles, stop after 1000 ticks.
`timescale 1ns/10ps
`default_nettype none
`include "irpd_params.svh"

module testbench;
	localparam int TICK = 32'hFA; // One tick in ns
	localparam int IDLE = 32'h3E8; // Stop timeout in ticks
	logic mclk; // System clock
	logic reset; // Async reset
	logic low_clk; // Filter clock
	logic ir_rx; // Pin from the remote
	logic [7:0] reg_addr; // Bus address
	logic [31:0] reg_wdata; // Bus write data
	logic reg_wr; // Write strobe
	logic reg_rd; // Read strobe
	logic [31:0] reg_rdata; // Bus read data
	logic irq; // Interrupt level
	logic [1:0] irq_prio; // Priority level
	logic [7:0] led; // LED outputs
	logic stopped; // Stopped state
	logic [31:0] word; // Frame sent
	logic [7:0] code; // Channel byte
	int n_errors = 0; // Mismatches
	int n_tests = 0; // Comparisons

	irpd_decoder #(.IDLE_TICKS(IDLE), .TICK_CYCLES(10)) i_irpd_decoder (.mclk(mclk), .reset(reset), .ir_rx(ir_rx),
		.subsystem_low_clock(low_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .irq_prio(irq_prio), .led(led),
		.autonomous_low_power_state(stopped));
	irpd_remote_model i_irpd_remote_model (.ir_rx(ir_rx));

	// 40 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Free-running low-speed clock, unrelated phase
	initial begin
		low_clk = 1'b0;
		forever #60 low_clk = ~low_clk;
	end

	// Verdict, the single exit
	task automatic conclude();
		$display("errors %0d of %0d checks", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	// One-cycle write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read, data taken at the falling edge inside the following cycle
	task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] got;
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		got = reg_rdata;
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t reg %h read %h expected %h", $time, a, got, exp);
		end
	endtask : check_reg

	// Output pins; priority is always level three
	task automatic check_pins(input logic [7:0] l, input logic i, input logic s);
		@(posedge mclk);
		n_tests++;
		if ({led, irq, stopped, irq_prio} !== {l, i, s, 2'h3}) begin
			n_errors++;
			$display("[ERR] %0t pins led %h irq %b stop %b prio %h", $time, led, irq, stopped, irq_prio);
		end
	endtask : check_pins

	// Hang guard, well past the expected run
	initial begin
		#(64'h231860);
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end

	// Main sequence
	initial begin
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		check_pins(8'h00, 1'b0, 1'b0);
		check_reg(`IRPD_REG_CTRL, 32'h3);
		check_reg(`IRPD_REG_STAT, 32'h0);
		check_reg(`IRPD_REG_IEN, 32'h0);
		check_reg(`IRPD_REG_DATA, 32'h0);
		check_reg(`IRPD_REG_CLR, 32'h0);
		check_reg(8'h20, 32'h0);
		wr(`IRPD_REG_STAT, 32'hF);
		check_reg(`IRPD_REG_STAT, 32'h0);
		// Every channel code, then one foreign code with a wrong address
		for (int n = 0; n < 9; n++) begin
			code = 8'h10 + n[7:0];
			word = {~code, code, (n == 8) ? 16'h0000 : 16'h6718};
			wr(`IRPD_REG_CLR, 32'hF);
			i_irpd_remote_model.send_frame(20, word, 32);
			#(2 * TICK);
			check_reg(`IRPD_REG_STAT, (n == 8) ? 32'h2 : 32'h3);
			check_reg(`IRPD_REG_DATA, word);
			check_pins((n < 8) ? (8'h01 << n) : 8'h00, 1'b0, 1'b0);
		end
		// Interrupt enable, mask and clear
		wr(`IRPD_REG_IEN, 32'h2);
		check_pins(8'h00, 1'b1, 1'b0);
		wr(`IRPD_REG_IEN, 32'h5);
		check_pins(8'h00, 1'b0, 1'b0);
		wr(`IRPD_REG_CLR, 32'h2);
		check_reg(`IRPD_REG_STAT, 32'h0);
		wr(`IRPD_REG_IEN, 32'h7);
		i_irpd_remote_model.send_repeat(20);
		#(2 * TICK);
		check_reg(`IRPD_REG_STAT, 32'h4);
		check_reg(`IRPD_REG_DATA, word);
		check_pins(8'h00, 1'b1, 1'b0);
		wr(`IRPD_REG_CLR, 32'hF);
		wr(`IRPD_REG_IEN, 32'h8);
		// Broken frame; last complete frame now over 900 ticks back, repeat 770
		i_irpd_remote_model.send_frame(500, 32'h0, 8);
		#(2 * TICK);
		check_reg(`IRPD_REG_STAT, 32'h0);
		check_reg(`IRPD_REG_DATA, word);
		check_pins(8'h00, 1'b0, 1'b0);
		#(400 * TICK);
		check_pins(8'h00, 1'b1, 1'b1);
		check_reg(`IRPD_REG_STAT, 32'h8);
		check_reg(`IRPD_REG_STATE, 32'h4);
		wr(`IRPD_REG_CLR, 32'hF);
		// Arriving frame while stopped wakes the system
		word = {8'hE8, 8'h17, 16'h6718};
		i_irpd_remote_model.send_frame(20, word, 32);
		#(2 * TICK);
		check_pins(8'h80, 1'b0, 1'b0);
		check_reg(`IRPD_REG_STAT, 32'h3);
		conclude();
	end
endmodule : testbench
`default_nettype wire
